// [design/spp_pkg.sv]
`default_nettype none
package spp_pkg;
    localparam logic [1:0] CTRL_ADDR = 2'h0;
    localparam logic [1:0] STAT_ADDR = 2'h1;
    localparam logic [1:0] DATA_ADDR = 2'h2;
    localparam int IRQ_EN_BIT = 7;
    localparam int PORT_EN_BIT = 6;
    localparam int LSB_FIRST_BIT = 5;
    localparam int MASTER_BIT = 4;
    localparam int CLOCK_IDLE_LEVEL_BIT = 3;
    localparam int CLOCK_SAMPLE_PHASE_BIT = 2;
    localparam int RATE_HI_BIT = 1;
    localparam int RATE_LO_BIT = 0;
    localparam int DONE_BIT = 7;
    localparam int WRITE_COLLISION_FLAG_BIT = 6;
    localparam int DOUBLE_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // SCK divisors in core_clk cycles per SCK period
    localparam logic [7:0] DIV_N0 = 8'h04;
    localparam logic [7:0] DIV_N1 = 8'h10;
    localparam logic [7:0] DIV_N2 = 8'h40;
    localparam logic [7:0] DIV_N3 = 8'h80;
    localparam logic [7:0] DIV_D0 = 8'h02;
    localparam logic [7:0] DIV_D1 = 8'h08;
    localparam logic [7:0] DIV_D2 = 8'h20;
    localparam logic [7:0] DIV_D3 = 8'h40;
    localparam logic [3:0] LAST_EDGE = 4'hF;
    localparam logic [3:0] LAST_SAMPLE = 4'h7;
endpackage
`default_nettype wire

// [design/spp_port.sv]
// Overview of operation
// - Slave with select low is active; MISO driven only if set as output.
// - Slave with select high stays passive and takes no data.
// - Select rising in slave role resets counter and drops partial byte.
// - Master with select pin as output ignores that pin.
// - Select low as input in master role clears master bit, pins input.
// - That forced drop also sets the transfer done flag.
// - Interrupt requested when done flag, enable bit 7, global enable.
// - No serial operation unless enable bit 6 is one.
// - Bit 5 one shifts LSB first, zero shifts MSB first.
// - Bit 4 picks master role; all control bits reset to zero.
// - Polarity bit sets SCK idle level and edge directions.
// - Phase zero samples on leading edge, one on trailing edge.
// - Master SCK is fosc over 4/16/64/128, or 2/8/32/64 doubled.
// - Done flag, status bit 7, sets when a byte completes.
// - Done flag clears when its interrupt vector runs.
// - Done flag clears on status read with flag, then data access.
// - Collision flag, status bit 6, sets on data write mid-transfer.
// - Status read with collision set, then data access, clears both.
// - Data write starts a transfer; data read returns receive buffer.
// - Shift out and latch in on opposite edges; modes 0 to 3.
// - Master write starts clock, shifts eight bits, stops, sets done.
// - Transmit single buffered, receive double; unread byte is lost.
// - Slave with select high keeps MISO released.
`timescale 1ns/1ps
`default_nettype none
module spp_port (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic global_irq_en,
    input wire logic irq_ack,
    output logic irq_req,
    input wire logic ss_is_output,
    input wire logic mosi_dir_out,
    input wire logic miso_dir_out,
    input wire logic sck_dir_out,
    input wire logic ss_in,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe
);
    function automatic logic head_bit(input logic [7:0] v,
                                      input logic lsb);
        head_bit = lsb ? v[0] : v[7];
    endfunction

    function automatic logic [6:0] half_cyc(input logic dbl,
                                           input logic [1:0] sel);
        logic [7:0] d;
        d = spp_pkg::DIV_N0;
        case ({dbl, sel})
            3'h0: d = spp_pkg::DIV_N0;
            3'h1: d = spp_pkg::DIV_N1;
            3'h2: d = spp_pkg::DIV_N2;
            3'h3: d = spp_pkg::DIV_N3;
            3'h4: d = spp_pkg::DIV_D0;
            3'h5: d = spp_pkg::DIV_D1;
            3'h6: d = spp_pkg::DIV_D2;
            default: d = spp_pkg::DIV_D3;
        endcase
        half_cyc = d[7:1];
    endfunction

    logic [7:0] ctrl_reg, ctrl_next;
    logic dbl_reg, done_reg, write_collision_flag_reg, arm_reg;
    logic [7:0] shift_reg, rx_reg, rdata_reg, rd_mux;
    logic out_bit_reg, busy_reg, sck_lvl_reg, irq_reg;
    logic [6:0] div_cnt_reg;
    logic [3:0] edge_cnt_reg, samp_cnt_reg;
    logic [1:0] sck_sy_reg, mosi_sy_reg, miso_sy_reg, ss_sy_reg;
    logic sck_prev_reg, ss_prev_reg;
    logic sck_oe_reg, mosi_oe_reg, miso_oe_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sck_sy_reg <= 2'h0;
            mosi_sy_reg <= 2'h0;
            miso_sy_reg <= 2'h0;
            ss_sy_reg <= 2'h3;
            sck_prev_reg <= 1'h0;
            ss_prev_reg <= 1'h1;
        end else begin
            sck_sy_reg <= {sck_sy_reg[0], sck_in};
            mosi_sy_reg <= {mosi_sy_reg[0], mosi_in};
            miso_sy_reg <= {miso_sy_reg[0], miso_in};
            ss_sy_reg <= {ss_sy_reg[0], ss_in};
            sck_prev_reg <= sck_sy_reg[1];
            ss_prev_reg <= ss_sy_reg[1];
        end
    end

    wire en = ctrl_reg[spp_pkg::PORT_EN_BIT];
    wire master_select = ctrl_reg[spp_pkg::MASTER_BIT];
    wire clock_idle_level = ctrl_reg[spp_pkg::CLOCK_IDLE_LEVEL_BIT];
    wire clock_sample_phase = ctrl_reg[spp_pkg::CLOCK_SAMPLE_PHASE_BIT];
    wire lsb = ctrl_reg[spp_pkg::LSB_FIRST_BIT];
    wire ss_lvl = ss_sy_reg[1];
    wire sck_lvl = sck_sy_reg[1];

    wire wr_ctrl = wr_en && addr == spp_pkg::CTRL_ADDR;
    wire wr_stat = wr_en && addr == spp_pkg::STAT_ADDR;
    wire wr_data = wr_en && addr == spp_pkg::DATA_ADDR;
    wire rd_stat = rd_en && addr == spp_pkg::STAT_ADDR;
    wire rd_data = rd_en && addr == spp_pkg::DATA_ADDR;
    wire data_acc = wr_data || rd_data;

    wire slave_act = en && !master_select && !ss_lvl;
    wire ss_rise = en && !master_select && ss_lvl && !ss_prev_reg;
    // Select pin only matters to a master when it is an input
    wire fault = en && master_select && !ss_is_output && !ss_lvl;
    wire xfer_act = busy_reg || (slave_act && samp_cnt_reg != 4'h0);
    wire write_collision_flag_set = wr_data && xfer_act;
    wire wr_ok = wr_data && !xfer_act;
    wire start = wr_ok && en && master_select && !fault;

    wire [6:0] half = half_cyc(dbl_reg,
        ctrl_reg[spp_pkg::RATE_HI_BIT:spp_pkg::RATE_LO_BIT]);
    wire tick = busy_reg && div_cnt_reg == half - 7'h01;
    wire m_lead = tick && sck_lvl_reg == clock_idle_level;
    wire m_trail = tick && sck_lvl_reg != clock_idle_level;
    wire s_rise = sck_lvl && !sck_prev_reg;
    wire s_fall = !sck_lvl && sck_prev_reg;
    wire s_lead = slave_act && (clock_idle_level ? s_fall : s_rise);
    wire s_trail = slave_act && (clock_idle_level ? s_rise : s_fall);
    wire lead = m_lead || s_lead;
    wire trail = m_trail || s_trail;
    wire samp = clock_sample_phase ? trail : lead;
    wire setup = clock_sample_phase ? lead : trail;
    wire in_bit = master_select ? miso_sy_reg[1] : mosi_sy_reg[1];
    wire [7:0] shift_nx = lsb ? {in_bit, shift_reg[7:1]}
                              : {shift_reg[6:0], in_bit};
    wire [7:0] shift_keep = samp ? shift_nx : shift_reg;
    wire s_done = slave_act && samp && samp_cnt_reg == spp_pkg::LAST_SAMPLE;
    wire m_done = tick && edge_cnt_reg == spp_pkg::LAST_EDGE;
    wire complete = s_done || m_done;
    wire data_clr = arm_reg && data_acc;

    always_comb begin
        ctrl_next = wr_ctrl ? wdata : ctrl_reg;
        if (fault)
            ctrl_next[spp_pkg::MASTER_BIT] = 1'h0;
    end

    always_comb begin
        if (addr == spp_pkg::CTRL_ADDR) begin
            rd_mux = ctrl_reg;
        end else if (addr == spp_pkg::STAT_ADDR) begin
            rd_mux = {done_reg, write_collision_flag_reg, 5'h00, dbl_reg};
        end else if (addr == spp_pkg::DATA_ADDR) begin
            rd_mux = rx_reg;
        end else begin
            rd_mux = 8'h00;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_reg <= spp_pkg::CTRL_RESET;
            dbl_reg <= 1'h0;
            rdata_reg <= 8'h00;
        end else begin
            ctrl_reg <= ctrl_next;
            if (wr_stat)
                dbl_reg <= wdata[spp_pkg::DOUBLE_BIT];
            rdata_reg <= rd_en ? rd_mux : 8'h00;
        end
    end

    // Set beats a clear landing in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            done_reg <= 1'h0;
            write_collision_flag_reg <= 1'h0;
            arm_reg <= 1'h0;
            irq_reg <= 1'h0;
        end else begin
            done_reg <= (done_reg && !(irq_ack || data_clr))
                || complete || fault;
            write_collision_flag_reg <= (write_collision_flag_reg && !data_clr) || write_collision_flag_set;
            if (rd_stat)
                arm_reg <= done_reg || write_collision_flag_reg;
            else if (data_acc)
                arm_reg <= 1'h0;
            irq_reg <= done_reg && global_irq_en
                && ctrl_reg[spp_pkg::IRQ_EN_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy_reg <= 1'h0;
            div_cnt_reg <= 7'h00;
            edge_cnt_reg <= 4'h0;
            sck_lvl_reg <= 1'h0;
        end else begin
            if (fault || !en)
                busy_reg <= 1'h0;
            else if (start)
                busy_reg <= 1'h1;
            else if (m_done)
                busy_reg <= 1'h0;
            div_cnt_reg <= (!busy_reg || tick) ? 7'h00
                : div_cnt_reg + 7'h01;
            if (!busy_reg)
                edge_cnt_reg <= 4'h0;
            else if (tick)
                edge_cnt_reg <= edge_cnt_reg + 4'h1;
            if (!busy_reg || fault)
                sck_lvl_reg <= clock_idle_level;
            else if (tick)
                sck_lvl_reg <= !sck_lvl_reg;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            shift_reg <= 8'h00;
            rx_reg <= 8'h00;
            samp_cnt_reg <= 4'h0;
            out_bit_reg <= 1'h0;
        end else begin
            if (wr_ok)
                shift_reg <= wdata;
            else if (ss_rise)
                shift_reg <= 8'h00;
            else if (samp)
                shift_reg <= shift_nx;
            if (complete)
                rx_reg <= shift_keep;
            if (complete || fault || (!busy_reg && !slave_act))
                samp_cnt_reg <= 4'h0;
            else if (samp)
                samp_cnt_reg <= samp_cnt_reg + 4'h1;
            if (wr_ok)
                out_bit_reg <= head_bit(wdata, lsb);
            else if (ss_rise)
                out_bit_reg <= 1'h0;
            else if (setup)
                out_bit_reg <= head_bit(shift_reg, lsb);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sck_oe_reg <= 1'h0;
            mosi_oe_reg <= 1'h0;
            miso_oe_reg <= 1'h0;
        end else begin
            sck_oe_reg <= en && master_select && !fault && sck_dir_out;
            mosi_oe_reg <= en && master_select && !fault && mosi_dir_out;
            miso_oe_reg <= slave_act && miso_dir_out;
        end
    end

    assign rdata = rdata_reg;
    assign irq_req = irq_reg;
    assign sck_out = sck_lvl_reg;
    assign sck_oe = sck_oe_reg;
    assign mosi_out = out_bit_reg;
    assign mosi_oe = mosi_oe_reg;
    assign miso_out = out_bit_reg;
    assign miso_oe = miso_oe_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_slave_quiet;
        en && !master_select && ss_lvl |=> !miso_oe && samp_cnt_reg == 4'h0;
    endproperty
    a_slave_quiet: assert property (p_slave_quiet)
        else $error("slave not passive with select high");

    property p_ss_drop;
        ss_rise && !wr_ok |=> shift_reg == 8'h00 && !xfer_act;
    endproperty
    a_ss_drop: assert property (p_ss_drop)
        else $error("select rise did not reset shifter");

    property p_fault;
        fault |=> !master_select && done_reg && !busy_reg ##1 !sck_oe && !mosi_oe;
    endproperty
    a_fault: assert property (p_fault)
        else $error("forced drop to slave mishandled");

    property p_irq;
        done_reg && global_irq_en && ctrl_reg[spp_pkg::IRQ_EN_BIT]
            |=> irq_req;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not requested");

    property p_disabled;
        !en |=> !sck_oe && !mosi_oe && !miso_oe && !busy_reg;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("port active while disabled");

    property p_write_collision_flag;
        wr_data && busy_reg |=> write_collision_flag_reg && shift_reg == $past(shift_keep);
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag)
        else $error("collision not flagged");

    sequence s_status_seen;
        rd_stat && (done_reg || write_collision_flag_reg);
    endsequence
    sequence s_data_touch;
        data_acc && !complete && !fault && !write_collision_flag_set && !rd_stat;
    endsequence
    property p_flag_clear;
        s_status_seen ##1 s_data_touch |=> !done_reg && !write_collision_flag_reg;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flags not cleared by read sequence");

    sequence s_bus_idle;
        !wr_en && !rd_en;
    endsequence
    property p_flag_clear_gap;
        s_status_seen ##1 s_bus_idle ##1 s_data_touch
            |=> !done_reg && !write_collision_flag_reg;
    endproperty
    a_flag_clear_gap: assert property (p_flag_clear_gap)
        else $error("flags not cleared after idle cycle");

    property p_ack_clear;
        done_reg && irq_ack && !data_clr && !complete && !fault
            |=> !done_reg;
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("vector did not clear done flag");

    sequence s_fast_start;
        start && half == 7'h01;
    endsequence
    property p_fast_byte;
        disable iff (rst || fault)
        s_fast_start |=> busy_reg[*8] ##9 (!busy_reg && done_reg);
    endproperty
    a_fast_byte: assert property (p_fast_byte)
        else $error("master byte length wrong");

    property p_sck_idle;
        !busy_reg |=> sck_out == $past(clock_idle_level);
    endproperty
    a_sck_idle: assert property (p_sck_idle)
        else $error("SCK not at idle level");
endmodule
`default_nettype wire

// [verif/spp_peer.sv]
`timescale 1ns/1ps
`default_nettype none
module spp_peer (
    input wire logic core_clk,
    input wire logic sck_w,
    input wire logic mosi_w,
    input wire logic miso_w,
    input wire logic clock_idle_level,
    input wire logic clock_sample_phase,
    input wire logic lsb,
    output logic miso_p,
    output logic sck_p,
    output logic mosi_p,
    output logic ss_n
);
    logic [7:0] tx_byte;
    logic [7:0] rx_byte;
    logic [7:0] rx_m;
    int s_cnt;
    int idx;
    function automatic logic bit_of(input logic [7:0] b, input int i);
        return lsb ? b[i] : b[7-i];
    endfunction
    function automatic logic [7:0] push(input logic [7:0] r, input logic b);
        return lsb ? {b, r[7:1]} : {r[6:0], b};
    endfunction
    initial begin
        {sck_p, miso_p, mosi_p, ss_n} = 4'hB;
        {tx_byte, rx_byte, rx_m} = 24'h0;
        s_cnt = 0;
    end
    // Slave side: first bit ready before the first edge when phase is 0
    task automatic load(input logic [7:0] b);
        tx_byte = b;
        s_cnt = 0;
        miso_p = clock_sample_phase ? ~miso_p : bit_of(b, 0);
    endtask
    always @(sck_w) begin
        #1;
        if ((sck_w != clock_idle_level) ^ clock_sample_phase) begin
            rx_byte = push(rx_byte, mosi_w);
        end else begin
            s_cnt++;
            idx = clock_sample_phase ? s_cnt - 1 : s_cnt;
            miso_p = (idx < 8) ? bit_of(tx_byte, idx) : ~miso_p;
        end
    end
    // Master side: half period of 8 core cycles, within quarter rate
    task automatic xfer(input logic [7:0] b, input int nb, input logic hi);
        @(posedge core_clk);
        sck_p <= clock_idle_level;
        @(posedge core_clk);
        ss_n <= hi;
        if (!clock_sample_phase) mosi_p <= bit_of(b, 0);
        for (int i = 0; i < nb; i++) begin
            repeat (8) @(posedge core_clk);
            sck_p <= ~clock_idle_level;
            if (clock_sample_phase) mosi_p <= bit_of(b, i);
            else rx_m = push(rx_m, miso_w);
            repeat (8) @(posedge core_clk);
            sck_p <= clock_idle_level;
            if (clock_sample_phase) rx_m = push(rx_m, miso_w);
            else if (i < 7) mosi_p <= bit_of(b, i + 1);
        end
        repeat (8) @(posedge core_clk);
        ss_n <= 1'h1;
        mosi_p <= ~mosi_p;
    endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk, rst, wr_en, rd_en, gie, irq_ack, irq_req, tb_ss;
    logic [1:0] addr;
    logic [7:0] wdata, rdata, v, tx, ptx;
    logic ss_is_output, mosi_dir_out, miso_dir_out, sck_dir_out;
    logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
    logic clock_idle_level, clock_sample_phase, lsb, ien, dbl, miso_p, sck_p, mosi_p, ss_n;
    int n_errors, samples_checked, seed, p, dv;
    wire logic sck_w = sck_oe ? sck_out : sck_p;
    wire logic mosi_w = mosi_oe ? mosi_out : mosi_p;
    wire logic miso_w = miso_oe ? miso_out : miso_p;
    spp_port u_dut (.core_clk(core_clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .global_irq_en(gie), .irq_ack(irq_ack), .irq_req(irq_req),
        .ss_is_output(ss_is_output), .mosi_dir_out(mosi_dir_out),
        .miso_dir_out(miso_dir_out), .sck_dir_out(sck_dir_out),
        .ss_in(ss_n & tb_ss), .sck_in(sck_w), .sck_out(sck_out),
        .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
        .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
        .miso_oe(miso_oe));
    spp_peer u_peer (.core_clk(core_clk), .sck_w(sck_w), .mosi_w(mosi_w),
        .miso_w(miso_w), .clock_idle_level(clock_idle_level), .clock_sample_phase(clock_sample_phase), .lsb(lsb),
        .miso_p(miso_p), .sck_p(sck_p), .mosi_p(mosi_p), .ss_n(ss_n));
    initial begin
        core_clk = 0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic check(input string nm, input logic [7:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'h1;
        @(posedge core_clk);
        wr_en <= 1'h0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'h1;
        @(posedge core_clk);
        rd_en <= 1'h0;
        #1;
        d = rdata;
    endtask
    task automatic wait_done(output logic [7:0] s);
        s = 8'h00;
        for (int k = 0; k < 3000 && s[7] !== 1'h1; k++) rd(spp_pkg::STAT_ADDR, s);
        check("done flag", 8'h01, {7'h00, s[7]});
    endtask
    // Period of master SCK in core cycles, over two toggles
    task automatic measure(output int per);
        logic last;
        int n, t1;
        #1;
        last = sck_out;
        n = 0;
        t1 = 0;
        per = 0;
        for (int c = 0; c < 600 && n < 3; c++) begin
            @(posedge core_clk);
            #1;
            if (sck_out !== last) begin
                n++;
                last = sck_out;
                if (n == 1) t1 = c;
                if (n == 3) per = c - t1;
            end
        end
    endtask
    function automatic int div_of(input logic d, input logic [1:0] s);
        int t [8] = '{4, 16, 64, 128, 2, 8, 32, 64};
        return t[{d, s}];
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #300000;
        n_errors++;
        give_verdict();
    end
    initial begin
        {rst, wr_en, rd_en, gie, irq_ack, tb_ss} = 6'h21;
        {addr, wdata, ien, dbl} = 12'h000;
        {ss_is_output, mosi_dir_out, miso_dir_out, sck_dir_out} = 4'h5;
        {clock_idle_level, clock_sample_phase, lsb} = 3'h0;
        n_errors = 0;
        samples_checked = 0;
        seed = 32'hafc989f8;
        repeat (20) @(posedge core_clk);
        rst <= 1'h0;
        rd(spp_pkg::CTRL_ADDR, v); check("control reset", 8'h00, v);
        rd(spp_pkg::STAT_ADDR, v); check("status reset", 8'h00, v);
        rd(2'h3, v); check("unmapped read", 8'h00, v);
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            {clock_idle_level, clock_sample_phase} = i[1:0];
            lsb = i[0] ^ i[2];
            dbl = i[2];
            ien = 1'($random(seed));
            gie <= 1'($random(seed));
            tx = 8'($random(seed));
            ptx = 8'($random(seed));
            dv = div_of(dbl, i[1:0]);
            wr(spp_pkg::CTRL_ADDR, {ien, 1'h1, lsb, 1'h1, clock_idle_level, clock_sample_phase, i[1:0]});
            wr(spp_pkg::STAT_ADDR, {7'h00, dbl});
            repeat (2) @(posedge core_clk);
            u_peer.load(ptx);
            wr(spp_pkg::DATA_ADDR, tx);
            wr(spp_pkg::DATA_ADDR, ~tx);
            measure(p);
            check("sck period", dv[7:0], p[7:0]);
            wait_done(v);
            check("collision flag", 8'h01, {7'h00, v[6]});
            check("irq request", {7'h00, ien & gie}, {7'h00, irq_req});
            if (i[0]) begin
                @(posedge core_clk);
                irq_ack <= 1'h1;
                @(posedge core_clk);
                irq_ack <= 1'h0;
                rd(spp_pkg::STAT_ADDR, v);
                check("done after ack", 8'h00, {7'h00, v[7]});
            end
            rd(spp_pkg::DATA_ADDR, v);
            if (dv >= 8) check("master rx", ptx, v);
            check("peer rx", tx, u_peer.rx_byte);
            check("sck idle", {7'h00, clock_idle_level}, {7'h00, sck_out});
            rd(spp_pkg::STAT_ADDR, v);
            check("flags cleared", {7'h00, dbl}, v);
        end
        $display("test master modes and rates done");
        {clock_idle_level, clock_sample_phase, lsb, gie} = 4'h0;
        wr(spp_pkg::STAT_ADDR, 8'h00);
        wr(spp_pkg::CTRL_ADDR, 8'h53);
        wr(spp_pkg::DATA_ADDR, 8'h3C);
        repeat (60) @(posedge core_clk);
        tb_ss <= 1'h0;
        repeat (8) @(posedge core_clk);
        #1;
        check("sck enable", 8'h00, {7'h00, sck_oe});
        check("mosi enable", 8'h00, {7'h00, mosi_oe});
        rd(spp_pkg::CTRL_ADDR, v); check("control", 8'h43, v);
        rd(spp_pkg::STAT_ADDR, v); check("drop done", 8'h80, v);
        tb_ss <= 1'h1;
        rd(spp_pkg::DATA_ADDR, v);
        repeat (1100) @(posedge core_clk);
        rd(spp_pkg::STAT_ADDR, v); check("abandoned", 8'h00, v);
        ss_is_output <= 1'h1;
        tb_ss <= 1'h0;
        wr(spp_pkg::CTRL_ADDR, 8'h51);
        repeat (2) @(posedge core_clk);
        ptx = 8'($random(seed));
        u_peer.load(ptx);
        wr(spp_pkg::DATA_ADDR, 8'hC3);
        wait_done(v);
        rd(spp_pkg::DATA_ADDR, v); check("output select rx", ptx, v);
        rd(spp_pkg::CTRL_ADDR, v); check("control kept", 8'h51, v);
        tb_ss <= 1'h1;
        // Let the select input settle high before it becomes an input
        repeat (3) @(posedge core_clk);
        ss_is_output <= 1'h0;
        $display("test select pin handling done");
        wr(spp_pkg::CTRL_ADDR, 8'h10);
        wr(spp_pkg::DATA_ADDR, 8'hA5);
        repeat (40) @(posedge core_clk);
        #1;
        check("disabled sck", 8'h00, {7'h00, sck_oe});
        rd(spp_pkg::STAT_ADDR, v); check("disabled status", 8'h00, v);
        {mosi_dir_out, sck_dir_out, miso_dir_out} <= 3'h1;
        for (int i = 0; i < 4; i++) begin
            {clock_idle_level, clock_sample_phase} = i[1:0];
            lsb = i[1];
            wr(spp_pkg::CTRL_ADDR, {2'h1, lsb, 1'h0, clock_idle_level, clock_sample_phase, 2'h0});
            tx = 8'($random(seed));
            ptx = 8'($random(seed));
            if (i == 0) begin
                u_peer.xfer(8'hFF, 8, 1'h1);
                rd(spp_pkg::STAT_ADDR, v); check("idle slave", 8'h00, v);
                u_peer.xfer(8'h00, 3, 1'h0);
                // Select rise must reach the shifter before the next load
                repeat (4) @(posedge core_clk);
            end
            wr(spp_pkg::DATA_ADDR, tx);
            u_peer.xfer(ptx, 8, 1'h0);
            check("slave tx", tx, u_peer.rx_m);
            repeat (4) @(posedge core_clk);
            #1;
            check("miso released", 8'h00, {7'h00, miso_oe});
            if (i == 3) begin
                ptx = 8'($random(seed));
                u_peer.xfer(ptx, 8, 1'h0);
            end
            wait_done(v);
            rd(spp_pkg::DATA_ADDR, v); check("slave rx", ptx, v);
        end
        $display("test slave modes done");
        give_verdict();
    end
endmodule
`default_nettype wire
